/* tap_ctrl_pkg.sv */
// Constants shared by the delay-line update controller.
package tap_ctrl_pkg;
	// ---------------------------------------------------------------
	// Register map and field layout
	// ---------------------------------------------------------------
	localparam int          ADR_W          = 8;
	localparam int          TAP_W          = 9;
	localparam int          TAP_COUNT      = 512;
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_TARGET     = 8'h04;
	localparam logic [7:0]  REG_STATUS     = 8'h08;
	localparam int          CTRL_TIME_BIT  = 0;
	localparam int          CTRL_LOAD_BIT  = 1;
	localparam int          CTRL_GO_BIT    = 2;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_RDY_BIT   = 1;
	localparam int          STAT_TAP_LSB   = 16;
	localparam logic        CTRL_TIME_RST  = 1'b1;
	localparam logic        CTRL_LOAD_RST  = 1'b0;
	localparam logic [8:0]  TARGET_RST     = 9'h000;
	// ---------------------------------------------------------------
	// Timing counts in control-clock cycles, tap jump limit and calibration frequency
	// ---------------------------------------------------------------
	localparam logic [3:0]  SETTLE_CYC     = 4'ha;
	localparam logic [3:0]  GAP_CYC        = 4'h5;
	localparam logic [3:0]  POST_CYC       = 4'ha;
	localparam logic [8:0]  MAX_JUMP       = 9'h008;
	localparam int          CAL_FREQ_MHZ   = 300;
	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RDY,
		ST_SETTLE,
		ST_CAPTURE,
		ST_DECIDE,
		ST_LOAD_SET,
		ST_GAP,
		ST_POST
	} seq_state_t;
endpackage

/* tap_update_ctrl.sv */
// Fabric controller that sequences updates of a programmable output delay line.
//
// Contract
// - Count format: no calibration, tracking enable low, frequency setting stays 300 MHz.
// - Time format: keep tracking enable high while calibration ready is low.
// - Fixed style: enable high in time format, low in count format.
// - Time format steps: lower enable, wait 10, step, wait 10, raise enable.
// - After each step command wait at least 5 cycles.
// - Count format single-step: enable stays low; only wait, step, post-wait.
// - Time load update: wait ready, lower enable, wait 10, capture tap count.
// - Move toward target by at most 8 taps per change.
// - Place value, wait one cycle, pulse load one cycle, wait 5 if unfinished.
// - Stepping alternative: set direction, one strobe per tap, count remaining to zero.
// - At target wait 10 cycles, then raise enable in time format.
// - Count load update: enable stays low, same capture, bounded step, post-wait.
// - All elements in a nibble share one frequency setting matching reference clock.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tap_update_ctrl #(
	parameter int CAL_FREQ_MHZ = tap_ctrl_pkg::CAL_FREQ_MHZ
) (
	input  wire logic                             CORE_CLK_I,
	input  wire logic                             RST_I,
	input  wire logic [tap_ctrl_pkg::ADR_W-1:0]   ADR_I,
	input  wire logic [31:0]                      DAT_I,
	output logic      [31:0]                      DAT_O,
	input  wire logic                             WE_I,
	input  wire logic [3:0]                       SEL_I,
	input  wire logic                             CYC_I,
	input  wire logic                             STB_I,
	output logic                                  ACK_O,
	input  wire logic [tap_ctrl_pkg::TAP_W-1:0]   TAP_VALUE_I,
	input  wire logic                             CAL_READY_I,
	output logic                                  VT_EN_O,
	output logic                                  STEP_O,
	output logic                                  DIR_O,
	output logic                                  LOAD_O,
	output logic      [tap_ctrl_pkg::TAP_W-1:0]   TAP_VALUE_O
);
	import tap_ctrl_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Next tap value toward the target, never more than the jump limit away.
	function automatic logic [8:0] toward(input logic [8:0] cur, input logic [8:0] tgt);
		logic [8:0] d;
		d = (tgt > cur) ? tgt - cur : cur - tgt;
		if (d <= MAX_JUMP) begin
			toward = tgt;
		end else if (tgt > cur) begin
			toward = cur + MAX_JUMP;
		end else begin
			toward = cur - MAX_JUMP;
		end
	endfunction

	// Register select on address bits 7:2; the low two address bits are ignored.
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] offs);
		hit = (adr[7:2] == offs[7:2]);
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	seq_state_t  state_r, state_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [8:0]  cur_r, cur_nxt;
	logic [8:0]  tgt_r, tgt_nxt;
	logic [8:0]  tap_seen_r, tap_seen_nxt;
	logic        time_r, time_nxt;
	logic        lds_r, lds_nxt;
	logic        go_r, go_nxt;
	logic        rdy_s1_r, rdy_s1_nxt, rdy_s2_r, rdy_s2_nxt;
	logic        rdy_s3_r, rdy_s3_nxt, rdy_r, rdy_nxt;
	logic        vt_r, vt_nxt;
	logic        step_r, step_nxt;
	logic        dir_r, dir_nxt;
	logic        load_r, load_nxt;
	logic [8:0]  tap_o_r, tap_o_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        req;
	logic        idle;

	assign VT_EN_O     = vt_r;
	assign STEP_O      = step_r;
	assign DIR_O       = dir_r;
	assign LOAD_O      = load_r;
	assign TAP_VALUE_O = tap_o_r;
	assign ACK_O       = ack_r;
	assign DAT_O       = dat_r;

	assign req  = CYC_I & STB_I & ~ack_r;
	assign idle = (state_r == ST_IDLE);

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	always_comb begin
		ack_nxt  = req;
		dat_nxt  = dat_r;
		time_nxt = time_r;
		lds_nxt  = lds_r;
		go_nxt   = 1'b0;
		tgt_nxt  = tgt_r;

		// Bus slave: one wait state, then a single-cycle ack.
		if (req) begin
			dat_nxt = 32'h0000_0000;
			if (hit(ADR_I, REG_CTRL)) begin
				dat_nxt[CTRL_TIME_BIT] = time_r;
				dat_nxt[CTRL_LOAD_BIT] = lds_r;
				if (WE_I && SEL_I[0] && idle) begin
					time_nxt = DAT_I[CTRL_TIME_BIT];
					lds_nxt  = DAT_I[CTRL_LOAD_BIT];
					go_nxt   = DAT_I[CTRL_GO_BIT];
				end
			end else if (hit(ADR_I, REG_TARGET)) begin
				dat_nxt[8:0] = tgt_r;
				if (WE_I && idle) begin
					if (SEL_I[0])
						tgt_nxt[7:0] = DAT_I[7:0];
					if (SEL_I[1])
						tgt_nxt[8] = DAT_I[8];
				end
			end else if (hit(ADR_I, REG_STATUS)) begin
				dat_nxt[STAT_BUSY_BIT] = ~idle;
				dat_nxt[STAT_RDY_BIT]  = rdy_r;
				dat_nxt[STAT_TAP_LSB +: TAP_W] = tap_seen_r;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			tgt_r  <= TARGET_RST;
			time_r <= CTRL_TIME_RST;
			lds_r  <= CTRL_LOAD_RST;
			go_r   <= 1'b0;
			ack_r  <= 1'b0;
			dat_r  <= 32'h0000_0000;
		end else begin
			tgt_r  <= tgt_nxt;
			time_r <= time_nxt;
			lds_r  <= lds_nxt;
			go_r   <= go_nxt;
			ack_r  <= ack_nxt;
			dat_r  <= dat_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Calibration ready synchroniser and tap monitor
	// ---------------------------------------------------------------
	// Ready comes from another clock, so a change counts once the last two flops agree.
	always_comb begin
		rdy_s1_nxt   = CAL_READY_I;
		rdy_s2_nxt   = rdy_s1_r;
		rdy_s3_nxt   = rdy_s2_r;
		rdy_nxt      = (rdy_s2_r == rdy_s3_r) ? rdy_s3_r : rdy_r;
		tap_seen_nxt = TAP_VALUE_I;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			rdy_s1_r   <= 1'b0;
			rdy_s2_r   <= 1'b0;
			rdy_s3_r   <= 1'b0;
			rdy_r      <= 1'b0;
			tap_seen_r <= 9'h000;
		end else begin
			rdy_s1_r   <= rdy_s1_nxt;
			rdy_s2_r   <= rdy_s2_nxt;
			rdy_s3_r   <= rdy_s3_nxt;
			rdy_r      <= rdy_nxt;
			tap_seen_r <= tap_seen_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Update sequencer
	// ---------------------------------------------------------------
	// The position is tracked here after the capture, so the tap bus is read once.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		cur_nxt   = cur_r;
		vt_nxt    = vt_r;
		step_nxt  = 1'b0;
		dir_nxt   = dir_r;
		load_nxt  = 1'b0;
		tap_o_nxt = tap_o_r;

		case (state_r)
			ST_IDLE: begin
				vt_nxt = time_r;
				if (go_r) begin
					if (time_r) begin
						state_nxt = ST_RDY;
					end else begin
						vt_nxt    = 1'b0;
						cnt_nxt   = SETTLE_CYC - 4'h1;
						state_nxt = ST_SETTLE;
					end
				end
			end
			ST_RDY: begin
				vt_nxt = 1'b1;
				if (rdy_r) begin
					vt_nxt    = 1'b0;
					cnt_nxt   = SETTLE_CYC - 4'h1;
					state_nxt = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (cnt_r == 4'h0) begin
					state_nxt = ST_CAPTURE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			ST_CAPTURE: begin
				cur_nxt   = TAP_VALUE_I;
				state_nxt = ST_DECIDE;
			end
			ST_DECIDE: begin
				if (cur_r == tgt_r) begin
					cnt_nxt   = POST_CYC - 4'h1;
					state_nxt = ST_POST;
				end else if (lds_r) begin
					tap_o_nxt = toward(cur_r, tgt_r);
					state_nxt = ST_LOAD_SET;
				end else begin
					dir_nxt   = (tgt_r > cur_r);
					step_nxt  = 1'b1;
					cur_nxt   = (tgt_r > cur_r) ? cur_r + 9'h001 : cur_r - 9'h001;
					cnt_nxt   = GAP_CYC;
					state_nxt = ST_GAP;
				end
			end
			ST_LOAD_SET: begin
				load_nxt  = 1'b1;
				cur_nxt   = tap_o_r;
				cnt_nxt   = GAP_CYC;
				state_nxt = ST_GAP;
			end
			ST_GAP: begin
				if (cnt_r == 4'h0) begin
					state_nxt = ST_DECIDE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			ST_POST: begin
				if (cnt_r == 4'h0) begin
					vt_nxt    = time_r;
					state_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Sequencer state and the delay-line control outputs.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			cur_r   <= 9'h000;
			vt_r    <= CTRL_TIME_RST;
			step_r  <= 1'b0;
			dir_r   <= 1'b0;
			load_r  <= 1'b0;
			tap_o_r <= 9'h000;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			cur_r   <= cur_nxt;
			vt_r    <= vt_nxt;
			step_r  <= step_nxt;
			dir_r   <= dir_nxt;
			load_r  <= load_nxt;
			tap_o_r <= tap_o_nxt;
		end
	end
endmodule // tap_update_ctrl

/* delay_line_model.sv */
// Behavioural model of the output delay line and its calibration controller.
`timescale 1ns/1ps
module delay_line_model #(
	parameter int         CAL_CYC  = 40,
	parameter logic [8:0] INIT_TAP = 9'h003
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       step_i,
	input  wire logic       dir_i,
	input  wire logic       load_i,
	input  wire logic [8:0] tap_i,
	output logic      [8:0] tap_o,
	output logic            rdy_o
);
	int cnt;
	always @(posedge clk_i) begin
		if (rst_i) begin
			tap_o <= INIT_TAP;
			cnt <= 0;
			rdy_o <= 1'b0;
		end else begin
			if (load_i) begin
				tap_o <= tap_i;
			end else if (step_i) begin
				tap_o <= dir_i ? tap_o + 9'h001 : tap_o - 9'h001;
			end
			if (cnt < CAL_CYC) begin
				cnt <= cnt + 1;
			end
			rdy_o <= (cnt >= CAL_CYC);
		end
	end
endmodule // delay_line_model

/* tap_update_ctrl_properties.sv */
// Concurrent checks on the ports of the delay-line update controller.
`timescale 1ns/1ps
module tap_update_ctrl_properties (
	input wire logic       CORE_CLK_I,
	input wire logic       RST_I,
	input wire logic       CYC_I,
	input wire logic       STB_I,
	input wire logic       ACK_O,
	input wire logic [8:0] TAP_VALUE_I,
	input wire logic       CAL_READY_I,
	input wire logic       VT_EN_O,
	input wire logic       STEP_O,
	input wire logic       LOAD_O,
	input wire logic [8:0] TAP_VALUE_O
);
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;
	logic [8:0] jump;
	default clocking @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);
	// ---------------------------------------------------------------
	// Helper logic
	// ---------------------------------------------------------------
	always_comb begin
		quiet_nxt = quiet_r;
		if (STEP_O || LOAD_O) begin
			quiet_nxt = 4'h0;
		end else if (quiet_r != 4'hf) begin
			quiet_nxt = quiet_r + 4'h1;
		end
		jump = (TAP_VALUE_O > TAP_VALUE_I) ? TAP_VALUE_O - TAP_VALUE_I : TAP_VALUE_I - TAP_VALUE_O;
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			quiet_r <= 4'hf;
		end else begin
			quiet_r <= quiet_nxt;
		end
	end
	sequence s_gap;
		(!STEP_O && !LOAD_O)[*5];
	endsequence
	sequence s_settle;
		(!STEP_O && !LOAD_O)[*5] ##1 (!STEP_O && !LOAD_O)[*5];
	endsequence
	a_ack_answer: assert property ((CYC_I && STB_I && !ACK_O) |=> ACK_O)
		else $error("ack missing after request");
	a_ack_pulse: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	a_pulse_gap: assert property ((STEP_O || LOAD_O) |=> s_gap)
		else $error("pulse gap shorter than five cycles");
	a_settle_quiet: assert property ($fell(VT_EN_O) |-> s_settle)
		else $error("pulse within settle time");
	a_post_quiet: assert property ($rose(VT_EN_O) |-> quiet_r >= 4'ha)
		else $error("enable raised too soon");
	a_jump_bound: assert property (LOAD_O |-> jump <= 9'h008)
		else $error("load jump above eight taps");
	a_load_setup: assert property (LOAD_O |-> $stable(TAP_VALUE_O))
		else $error("load value not set a cycle ahead");
	a_vt_ready: assert property ($fell(VT_EN_O) |-> CAL_READY_I && $past(CAL_READY_I, 2))
		else $error("enable lowered before ready");
	a_pulse_vt_low: assert property ((STEP_O || LOAD_O) |-> !VT_EN_O)
		else $error("pulse with tracking on");
endmodule // tap_update_ctrl_properties
bind tap_update_ctrl tap_update_ctrl_properties tap_update_ctrl_properties_inst (
	.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
	.TAP_VALUE_I(TAP_VALUE_I), .CAL_READY_I(CAL_READY_I), .VT_EN_O(VT_EN_O),
	.STEP_O(STEP_O), .LOAD_O(LOAD_O), .TAP_VALUE_O(TAP_VALUE_O));

/* testbench.sv */
// Self-checking bench for the delay-line update controller.
`timescale 1ns/1ps
module testbench;
	import tap_ctrl_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack, vt, step, dir, load, rdy;
	logic [8:0]  tap_set, tap_now;
	int          bad_count = 0;
	int          n_checks = 0;
	always #50 clk = ~clk;
	tap_update_ctrl tap_update_ctrl_inst (.CORE_CLK_I(clk), .RST_I(rst), .ADR_I(adr),
		.DAT_I(dat), .DAT_O(rdat), .WE_I(we), .SEL_I(4'hf), .CYC_I(cyc), .STB_I(stb),
		.ACK_O(ack), .TAP_VALUE_I(tap_now), .CAL_READY_I(rdy), .VT_EN_O(vt),
		.STEP_O(step), .DIR_O(dir), .LOAD_O(load), .TAP_VALUE_O(tap_set));
	delay_line_model delay_line_model_inst (.clk_i(clk), .rst_i(rst), .step_i(step),
		.dir_i(dir), .load_i(load), .tap_i(tap_set), .tap_o(tap_now), .rdy_o(rdy));
	task automatic close_out();
		if (bad_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		we <= w;
		dat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			chk(32'h1, 32'h0);
			close_out();
		end
	endtask
	task automatic upd(input logic [8:0] t, input logic [2:0] c, input logic v);
		int n;
		n = 0;
		wb(REG_TARGET, 1'b1, {23'h0, t});
		wb(REG_CTRL, 1'b1, {29'h0, c});
		wb(REG_TARGET, 1'b1, 32'h1ff);
		wb(REG_STATUS, 1'b0, 32'h0);
		chk(q & 32'h1, 32'h1);
		do begin
			if (rdy !== 1'b1 && c[0]) chk(32'(vt), 32'h1);
			wb(REG_STATUS, 1'b0, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 100);
		chk(q, {7'h00, t, 16'h0002});
		if (n >= 100) close_out();
		wb(REG_TARGET, 1'b0, 32'h0);
		chk(q, {23'h0, t});
		wb(REG_CTRL, 1'b0, 32'h0);
		chk(q, {30'h0, c[1:0]});
		chk(32'(tap_now), {23'h0, t});
		chk(32'(vt), 32'(v));
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(REG_CTRL, 1'b0, 32'h0);
		chk(q, 32'h1);
		chk(32'(vt), 32'h1);
		wb(8'h0c, 1'b0, 32'h0);
		chk(q, 32'h0);
		upd(9'h005, 3'h5, 1'b1);
		upd(9'h002, 3'h4, 1'b0);
		upd(9'h01c, 3'h6, 1'b0);
		upd(9'h000, 3'h7, 1'b1);
		close_out();
	end
endmodule // testbench
